/* File: hw/codec_frame_pkg.sv */
// Constants for the speech codec frame interface.
// Assumes one 125 MHz system clock and a synchronous reset.
// Behaviour
// - Every sample and parameter is a 16-bit word.
// - Each 20 ms of samples yields 76 words.
// - Reset sets encoder-side state before samples.
// - Reset returns decoder-side state to initial values.
// - Encoder samples input every 8 kHz tick.
// - Decoder outputs samples every 8 kHz tick.
// - Input sample is 13 bits, left-justified.
// - Log-area codes one to four: 6,6,5,5 bits.
// - Log-area codes five to eight: 4,4,3,3 bits.
// - Subframe: lag 7, gain 2, grid 2, amplitude 6, then 3-bit pulses.
// - Block amplitude is 6 bits, full range.
// - Grid position is 2 bits, right-justified.
// - Decoder takes any lag code 0 to 127.
// - Out-of-range lag reuses last, starts at 40.
// - Output sample 13 bits, three low zeros.
package codec_frame_pkg;
  localparam int WORD_W = 16; // Word width
  localparam int SMP_W = 13; // Significant sample bits
  localparam int PAD_W = WORD_W - SMP_W; // Zero bits under sample
  localparam int FRAME_WORDS = 76; // Words per frame
  localparam int LAR_WORDS = 8; // Log-area words at frame head
  localparam int SUB_WORDS = 17; // Words per subframe
  localparam int CLK_NS = 8; // Clock period, ns
  localparam int SAMPLE_NS = 125000; // 8 kHz period, ns
  localparam int TICK_CYC = SAMPLE_NS / CLK_NS; // Cycles per sample
  localparam int FRAME_MS = 20; // Frame length, ms
  localparam int FRAME_SMP = FRAME_MS * 1000000 / SAMPLE_NS; // 160
  localparam logic [6:0] LAG_MIN = 7'h28; // 40
  localparam logic [6:0] LAG_MAX = 7'h78; // 120
  localparam logic [6:0] LAG_INIT = 7'h28; // Remembered lag at reset
  localparam logic [6:0] IDX_LAST = 7'h4b; // 75
  localparam logic [6:0] IDX_FIRST = 7'h00;

  // Field width for a word position within the frame
  function automatic logic [2:0] field_width(input logic [6:0] idx);
    logic [6:0] s;
    s = 7'h00;
    if (idx < 7'(LAR_WORDS)) begin
      field_width = 3'h6 - 3'(idx[2:1]); // 6,6,5,5,4,4,3,3
    end else begin
      s = 7'((idx - 7'(LAR_WORDS)) % 7'(SUB_WORDS));
      unique case (s)
        7'h00: field_width = 3'h7; // Pitch lag
        7'h01: field_width = 3'h2; // Pitch gain
        7'h02: field_width = 3'h2; // Grid position
        7'h03: field_width = 3'h6; // Block amplitude
        default: field_width = 3'h3; // Pulse codes
      endcase
    end
  endfunction : field_width

  // True where the word carries a pitch lag
  function automatic logic is_lag(input logic [6:0] idx);
    is_lag = (idx >= 7'(LAR_WORDS)) &&
             (7'((idx - 7'(LAR_WORDS)) % 7'(SUB_WORDS)) == 7'h00);
  endfunction : is_lag

  // Keep only the field's low bits, right-justified
  function automatic logic [15:0] fit(input logic [15:0] w, input logic [6:0] idx);
    fit = w & ((16'h0001 << field_width(idx)) - 16'h0001);
  endfunction : fit
endpackage : codec_frame_pkg

/* File: hw/word_fifo.sv */
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock and synchronous reset.
`timescale 1ns/10ps
module word_fifo #(
  parameter int W = 17,
  parameter int D = 8
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D]; // Storage
  logic [AW-1:0] wp, rp, next_wp, next_rp; // Pointers
  logic [AW:0] cnt, next_cnt; // Fill level
  logic push, pop;

  assign in_ready = (cnt != (AW+1)'(D)); // Honest full
  assign out_valid = (cnt != '0); // Honest empty
  assign out_data = mem[rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and level update
  always_comb begin
    next_wp = push ? AW'((wp + 1'b1) % D) : wp;
    next_rp = pop ? AW'((rp + 1'b1) % D) : rp;
    next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
    if (push) begin
      mem[wp] <= in_data; // Data path needs no reset
    end
  end
endmodule : word_fifo

/* File: hw/speech_codec_frame_interface.sv */
// Word-level framing of a speech codec: sample pacing, parameter
// frames out of the encoder, parameter frames into the decoder.
// Assumes the codec core sits on the user side on the same clock and
// test equipment on the other side is synchronous to clk_sys.
`timescale 1ns/10ps
module speech_codec_frame_interface #(
  parameter int TICK_CYCLES = codec_frame_pkg::TICK_CYC,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic srst,
  // Encoder sample input from test equipment
  input wire logic [15:0] enc_sample_word,
  // Sample handed to the encoder core
  output logic [12:0] core_sample,
  output logic core_sample_valid,
  output logic core_frame_end,
  // Raw parameters from the encoder core
  input wire logic [15:0] core_param,
  input wire logic core_param_valid,
  output logic core_param_ready,
  // Encoded frame words to test equipment
  output logic [15:0] enc_word,
  output logic enc_word_sof,
  output logic enc_word_valid,
  input wire logic enc_word_ready,
  // Encoded frame words from test equipment
  input wire logic [15:0] dec_word,
  input wire logic dec_word_sof,
  input wire logic dec_word_valid,
  output logic dec_word_ready,
  // Decoded fields handed to the decoder core
  output logic [15:0] dec_field,
  output logic [6:0] dec_field_index,
  output logic dec_field_valid,
  output logic [6:0] decoded_pitch_lag,
  // Samples from the decoder core and to test equipment
  input wire logic [15:0] core_out_sample,
  output logic [15:0] dec_sample_word,
  output logic dec_sample_valid,
  output logic dec_frame_late
);
  localparam int TW = $clog2(TICK_CYCLES);
  localparam int FW = $clog2(codec_frame_pkg::FRAME_SMP);

  // 8 kHz tick divider
  logic [TW-1:0] div, next_div;
  logic tick;
  assign tick = (div == TW'(TICK_CYCLES - 1));

  always_comb begin
    next_div = tick ? '0 : div + 1'b1;
  end

  // Divider register; reset lines the ticks up with the test equipment
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      div <= '0;
    end else begin
      div <= next_div;
    end
  end

  // Encoder side: sample capture and frame boundary count
  logic [FW-1:0] enc_smp, next_enc_smp; // Samples in current frame
  logic [12:0] next_core_sample;
  logic next_frame_end;

  always_comb begin
    next_enc_smp = enc_smp;
    next_core_sample = core_sample;
    next_frame_end = 1'b0;
    if (tick) begin
      // Sample taken every tick, never stalled
      next_core_sample = enc_sample_word[15 -: codec_frame_pkg::SMP_W];
      if (enc_smp == FW'(codec_frame_pkg::FRAME_SMP - 1)) begin
        next_enc_smp = '0;
        next_frame_end = 1'b1;
      end else begin
        next_enc_smp = enc_smp + 1'b1;
      end
    end
  end

  // Encoder sample registers; core_sample holds between ticks
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      enc_smp <= '0;
      core_sample <= '0;
      core_sample_valid <= 1'b0;
      core_frame_end <= 1'b0;
    end else begin
      enc_smp <= next_enc_smp;
      core_sample <= next_core_sample;
      core_sample_valid <= tick;
      core_frame_end <= next_frame_end;
    end
  end

  // Encoder side: parameter formatting into the output FIFO
  logic [6:0] enc_idx, next_enc_idx; // Word position in frame
  logic push, fifo_in_ready;
  logic [15:0] push_word;
  logic push_sof;

  assign core_param_ready = fifo_in_ready; // Stall reaches the core
  assign push = core_param_valid && fifo_in_ready;
  assign push_word = codec_frame_pkg::fit(core_param, enc_idx);
  assign push_sof = (enc_idx == codec_frame_pkg::IDX_FIRST);

  always_comb begin
    next_enc_idx = enc_idx;
    if (push) begin
      // Wrap after the 76th word
      next_enc_idx = (enc_idx == codec_frame_pkg::IDX_LAST) ?
                     codec_frame_pkg::IDX_FIRST : enc_idx + 7'h01;
    end
  end

  // Encoder word position register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      enc_idx <= codec_frame_pkg::IDX_FIRST;
    end else begin
      enc_idx <= next_enc_idx;
    end
  end

  word_fifo #(.W(17), .D(FIFO_DEPTH)) word_fifo_i (
    .clk_sys(clk_sys),
    .srst(srst),
    .in_data({push_sof, push_word}),
    .in_valid(core_param_valid),
    .in_ready(fifo_in_ready),
    .out_data({enc_word_sof, enc_word}),
    .out_valid(enc_word_valid),
    .out_ready(enc_word_ready)
  );

  // Decoder side: word intake, field extraction and lag check
  logic [6:0] dec_idx, next_dec_idx; // Expected word position
  logic [6:0] next_lag;
  logic [15:0] next_field;
  logic [6:0] next_field_index;
  logic take, cur_lag_ok;
  logic [6:0] cur_pos; // Position of the word being taken
  logic [6:0] raw_lag;

  assign dec_word_ready = 1'b1; // Word rate is far below clock rate
  assign take = dec_word_valid;
  // A marked word always restarts the frame
  assign cur_pos = dec_word_sof ? codec_frame_pkg::IDX_FIRST : dec_idx;
  assign raw_lag = dec_word[6:0]; // Any of 0..127 accepted
  assign cur_lag_ok = (raw_lag >= codec_frame_pkg::LAG_MIN) &&
                      (raw_lag <= codec_frame_pkg::LAG_MAX);

  always_comb begin
    next_dec_idx = dec_idx;
    next_lag = decoded_pitch_lag;
    next_field = dec_field;
    next_field_index = dec_field_index;
    if (take) begin
      next_field = codec_frame_pkg::fit(dec_word, cur_pos);
      next_field_index = cur_pos;
      next_dec_idx = (cur_pos == codec_frame_pkg::IDX_LAST) ?
                     codec_frame_pkg::IDX_FIRST : cur_pos + 7'h01;
      if (codec_frame_pkg::is_lag(cur_pos)) begin
        // Bad lags fall back to the last good one
        next_lag = cur_lag_ok ? raw_lag : decoded_pitch_lag;
        next_field = {9'h000, next_lag};
      end
    end
  end

  // Decoder field registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dec_idx <= codec_frame_pkg::IDX_FIRST;
      decoded_pitch_lag <= codec_frame_pkg::LAG_INIT;
      dec_field <= '0;
      dec_field_index <= '0;
      dec_field_valid <= 1'b0;
    end else begin
      dec_idx <= next_dec_idx;
      decoded_pitch_lag <= next_lag;
      dec_field <= next_field;
      dec_field_index <= next_field_index;
      dec_field_valid <= take;
    end
  end

  // Decoder side: continuous 8 kHz output and frame lateness watch
  logic [FW-1:0] dec_smp, next_dec_smp; // Output samples this frame
  logic frame_in, next_frame_in; // Full frame seen this period
  logic next_late;
  logic [15:0] next_out;
  logic dec_frame_done;

  assign dec_frame_done = take && (cur_pos == codec_frame_pkg::IDX_LAST);

  always_comb begin
    next_dec_smp = dec_smp;
    next_frame_in = frame_in || dec_frame_done;
    next_late = dec_frame_late;
    next_out = dec_sample_word;
    if (tick) begin
      // Output never pauses, even if the feeder is late
      next_out = {core_out_sample[15 -: codec_frame_pkg::SMP_W],
                  {codec_frame_pkg::PAD_W{1'b0}}};
      if (dec_smp == FW'(codec_frame_pkg::FRAME_SMP - 1)) begin
        next_dec_smp = '0;
        // Sticky until reset; feeder missed its 20 ms window
        next_late = dec_frame_late || !next_frame_in;
        next_frame_in = 1'b0;
      end else begin
        next_dec_smp = dec_smp + 1'b1;
      end
    end
  end

  // Decoder output registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dec_smp <= '0;
      frame_in <= 1'b0;
      dec_frame_late <= 1'b0;
      dec_sample_word <= '0;
      dec_sample_valid <= 1'b0;
    end else begin
      dec_smp <= next_dec_smp;
      frame_in <= next_frame_in;
      dec_frame_late <= next_late;
      dec_sample_word <= next_out;
      dec_sample_valid <= tick;
    end
  end

  // Checks
  sequence s_tick_quiet;
    tick ##1 !tick [*8];
  endsequence

  a_tick_spacing: assert property (@(posedge clk_sys) disable iff (srst)
    tick |-> s_tick_quiet) else $error("sample ticks too close");
  a_sample_left_just: assert property (@(posedge clk_sys) disable iff (srst)
    tick |=> core_sample_valid && core_sample == $past(enc_sample_word[15:3]))
    else $error("input sample not captured left-justified");
  a_sof_first_word: assert property (@(posedge clk_sys) disable iff (srst)
    push && $past(push && enc_idx == codec_frame_pkg::IDX_LAST) |-> push_sof)
    else $error("frame start not marked after wrap");
  a_field_fits: assert property (@(posedge clk_sys) disable iff (srst)
    push |-> (push_word >> codec_frame_pkg::field_width(enc_idx)) == 16'h0000)
    else $error("field exceeds its width");
  a_frame_wraps: assert property (@(posedge clk_sys) disable iff (srst)
    push && enc_idx == codec_frame_pkg::IDX_LAST |=> enc_idx == codec_frame_pkg::IDX_FIRST)
    else $error("frame did not end at word 76");
  a_bad_lag_kept: assert property (@(posedge clk_sys) disable iff (srst)
    take && codec_frame_pkg::is_lag(cur_pos) && !cur_lag_ok
    |=> decoded_pitch_lag == $past(decoded_pitch_lag) && dec_field_valid)
    else $error("bad lag not replaced");
  a_good_lag_taken: assert property (@(posedge clk_sys) disable iff (srst)
    take && codec_frame_pkg::is_lag(cur_pos) && cur_lag_ok
    |=> decoded_pitch_lag == $past(dec_word[6:0]))
    else $error("good lag not taken");
  a_out_truncated: assert property (@(posedge clk_sys) disable iff (srst)
    tick |=> dec_sample_valid && dec_sample_word == {$past(core_out_sample[15:3]), 3'h0})
    else $error("output sample not truncated");
  a_reset_state: assert property (@(posedge clk_sys)
    srst |=> decoded_pitch_lag == codec_frame_pkg::LAG_INIT && !dec_frame_late)
    else $error("reset state wrong");
  // Frame end only rides on a sample pulse
  a_frame_end_pulse: assert property (@(posedge clk_sys) disable iff (srst)
    core_frame_end |-> core_sample_valid)
    else $error("frame end without a sample");
  // Sample pulses last exactly one cycle
  a_sample_one_cycle: assert property (@(posedge clk_sys) disable iff (srst)
    core_sample_valid |=> !core_sample_valid)
    else $error("sample pulse held too long");
  // Late flag only drops on reset
  a_late_sticky: assert property (@(posedge clk_sys) disable iff (srst)
    dec_frame_late |=> dec_frame_late)
    else $error("late flag dropped without reset");
  // A marked word always lands at position zero
  a_sof_restarts: assert property (@(posedge clk_sys) disable iff (srst)
    take && dec_word_sof |=> dec_field_valid && dec_field_index == codec_frame_pkg::IDX_FIRST)
    else $error("marked word not placed at frame start");
  // Decoded fields never exceed their width
  a_dec_field_fits: assert property (@(posedge clk_sys) disable iff (srst)
    dec_field_valid |-> (dec_field >> codec_frame_pkg::field_width(dec_field_index)) == 16'h0000)
    else $error("decoded field exceeds its width");
  // Output samples keep their low bits clear
  a_out_low_clear: assert property (@(posedge clk_sys) disable iff (srst)
    dec_sample_valid |-> dec_sample_word[codec_frame_pkg::PAD_W-1:0] == '0)
    else $error("output sample low bits set");
  // Remembered lag never leaves the legal range
  a_lag_in_range: assert property (@(posedge clk_sys) disable iff (srst)
    decoded_pitch_lag >= codec_frame_pkg::LAG_MIN && decoded_pitch_lag <= codec_frame_pkg::LAG_MAX)
    else $error("remembered lag out of range");
  // A full buffer stalls the core without losing position
  a_full_stalls: assert property (@(posedge clk_sys) disable iff (srst)
    core_param_valid && !core_param_ready |=> $stable(enc_idx))
    else $error("word position moved while stalled");
endmodule : speech_codec_frame_interface

/* File: bench/frame_sink_model.sv */
// Test equipment that takes encoded frame words from the block.
// Assumes it shares clk_sys and srst with the block.
`timescale 1ns/10ps
module frame_sink_model (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic stall,
  output logic enc_word_ready
);
  // Ready moves only after an edge; slow mode takes about one word in four
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      enc_word_ready <= 1'b0; // Nothing taken in reset
    end else begin
      enc_word_ready <= stall ? ($urandom % 4 == 0) : 1'b1;
    end
  end
endmodule : frame_sink_model

/* File: bench/speech_codec_frame_interface_bench.sv */
// Self-checking bench for the speech codec frame interface.
// Assumes a shortened sample period and the frame sink model.
`timescale 1ns/10ps
module speech_codec_frame_interface_bench;
  localparam int TICK = 16; // Short sample period keeps the run small
  logic clk_sys, srst, stall, core_param_valid, dec_word_sof, dec_word_valid;
  logic [15:0] enc_sample_word, core_param, dec_word, core_out_sample;
  logic [12:0] core_sample;
  logic core_sample_valid, core_frame_end, core_param_ready, enc_word_sof;
  logic [15:0] enc_word, dec_field, dec_sample_word;
  logic enc_word_valid, enc_word_ready, dec_word_ready, dec_field_valid;
  logic [6:0] dec_field_index, decoded_pitch_lag;
  logic dec_sample_valid, dec_frame_late;
  int fails, cmp_count, refused, nsmp, gap, armed;
  logic [16:0] enc_q[$]; // Expected {sof, word}
  logic [22:0] dec_q[$]; // Expected {index, field}
  logic [28:0] smp_q[$]; // Expected {core_sample, dec_sample_word}
  logic [6:0] last_lag; // Remembered good lag
  // Lags for two frames: in and out of range, both edges
  logic [6:0] lag_tab[8] = '{7'h27, 7'h28, 7'h78, 7'h79, 7'h00, 7'h7f, 7'h4d, 7'h29};

  speech_codec_frame_interface #(.TICK_CYCLES(TICK), .FIFO_DEPTH(8)) speech_codec_frame_interface_i (
    .clk_sys(clk_sys), .srst(srst), .enc_sample_word(enc_sample_word),
    .core_sample(core_sample), .core_sample_valid(core_sample_valid),
    .core_frame_end(core_frame_end), .core_param(core_param),
    .core_param_valid(core_param_valid), .core_param_ready(core_param_ready),
    .enc_word(enc_word), .enc_word_sof(enc_word_sof), .enc_word_valid(enc_word_valid),
    .enc_word_ready(enc_word_ready), .dec_word(dec_word), .dec_word_sof(dec_word_sof),
    .dec_word_valid(dec_word_valid), .dec_word_ready(dec_word_ready),
    .dec_field(dec_field), .dec_field_index(dec_field_index),
    .dec_field_valid(dec_field_valid), .decoded_pitch_lag(decoded_pitch_lag),
    .core_out_sample(core_out_sample), .dec_sample_word(dec_sample_word),
    .dec_sample_valid(dec_sample_valid), .dec_frame_late(dec_frame_late));

  frame_sink_model frame_sink_model_i (
    .clk_sys(clk_sys), .srst(srst), .stall(stall), .enc_word_ready(enc_word_ready));

  // Field mask for a frame position, worked out independently
  function automatic logic [15:0] mask_of(input int i);
    int s;
    s = (i - 8) % 17;
    if (i < 8) return 16'((32'h1 << (6 - i / 2)) - 1);
    case (s)
      0: return 16'h007f;
      1, 2: return 16'h0003;
      3: return 16'h003f;
      default: return 16'h0007;
    endcase
  endfunction : mask_of

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  // Encoder output word with its frame mark
  task automatic chk_enc(input logic [16:0] got, input logic [16:0] exp);
    chk_word(32'(got), 32'(exp));
  endtask : chk_enc

  // Decoder field with its frame position
  task automatic chk_field(input logic [22:0] got, input logic [22:0] exp);
    chk_word(32'(got), 32'(exp));
  endtask : chk_field

  // Captured input sample with the output sample of the same tick
  task automatic chk_smp(input logic [28:0] got, input logic [28:0] exp);
    chk_word(32'(got), 32'(exp));
  endtask : chk_smp

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // Bounded step; running out counts as a mismatch
  task automatic step(inout int n);
    @(negedge clk_sys);
    n++;
    if (n > 6000) begin
      fails++;
      report_and_stop();
    end
  endtask : step

  // One encoder word from the core side, held until taken
  task automatic send_param(input int i);
    logic [15:0] raw;
    int n;
    raw = 16'($urandom);
    n = 0;
    enc_q.push_back({i == 0, raw & mask_of(i)});
    core_param = raw;
    core_param_valid = 1'b1;
    while (!core_param_ready) step(n);
    @(negedge clk_sys);
  endtask : send_param

  // One decoder word with a random gap after it
  task automatic send_dec(input int i, input int f);
    logic [15:0] raw;
    int n;
    raw = 16'($urandom);
    if (i >= 8 && (i - 8) % 17 == 0) begin
      raw[6:0] = lag_tab[f * 4 + (i - 8) / 17];
      if (raw[6:0] >= codec_frame_pkg::LAG_MIN && raw[6:0] <= codec_frame_pkg::LAG_MAX) begin
        last_lag = raw[6:0];
      end
      dec_q.push_back({7'(i), 9'h000, last_lag});
    end else begin
      dec_q.push_back({7'(i), raw & mask_of(i)});
    end
    dec_word = raw;
    dec_word_sof = (i == 0);
    dec_word_valid = 1'b1;
    @(negedge clk_sys);
    n = $urandom % 3;
    if (n > 0) begin
      dec_word_valid = 1'b0;
      repeat (n) @(negedge clk_sys);
    end
  endtask : send_dec

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // New sample inputs after each capture; the result is noted at once
  always @(negedge clk_sys) begin
    if (core_sample_valid) begin
      enc_sample_word = 16'($urandom);
      core_out_sample = 16'($urandom);
      smp_q.push_back({enc_sample_word[15:3], core_out_sample[15:3], 3'h0});
    end
  end

  // Watch outputs mid-cycle, where they are settled, and take the oldest note
  always @(negedge clk_sys) begin
    gap++;
    if (srst) begin
      armed = 0;
      nsmp = 0;
    end
    if (core_param_valid && !core_param_ready) refused++;
    if (enc_word_valid && enc_word_ready) begin
      chk_enc({enc_word_sof, enc_word}, enc_q.pop_front());
    end
    if (dec_field_valid) begin
      chk_field({dec_field_index, dec_field}, dec_q.pop_front());
    end
    if (core_sample_valid) begin
      chk_smp({core_sample, dec_sample_word}, smp_q.pop_front());
      chk_word(32'(core_frame_end), 32'(nsmp % 160 == 159));
      nsmp++;
    end
    if (dec_sample_valid) begin
      if (armed) chk_word(32'(gap), 32'(TICK));
      gap = 0;
      armed = 1;
    end
  end

  initial begin
    int n;
    void'($urandom(32'h530e));
    {fails, cmp_count, refused, nsmp, gap, armed, n} = '0;
    {core_param, dec_word, core_param_valid, dec_word_sof, dec_word_valid} = '0;
    srst = 1'b1;
    stall = 1'b0;
    last_lag = 7'h28;
    enc_sample_word = 16'($urandom);
    core_out_sample = 16'($urandom);
    smp_q.push_back({enc_sample_word[15:3], core_out_sample[15:3], 3'h0});
    repeat (20) @(negedge clk_sys);
    srst = 1'b0;
    chk_word(32'(decoded_pitch_lag), 32'h28);
    for (int f = 0; f < 3; f++) begin
      stall = (f == 1);
      for (int i = 0; i < 76; i++) send_param(i);
      if (f != 0) core_param_valid = 1'b0;
      if (f == 1) begin
        for (int g = 0; g < 2; g++) begin
          for (int i = 0; i < 76; i++) send_dec(i, g);
        end
        dec_word_valid = 1'b0;
        while (enc_q.size() > 0 || dec_q.size() > 0 || nsmp < 320) step(n);
        chk_word(32'(decoded_pitch_lag), 32'h29);
        chk_word(32'({dec_word_ready, dec_frame_late}), 32'h3);
        srst = 1'b1;
        repeat (2) @(negedge clk_sys);
        srst = 1'b0;
        chk_word(32'({decoded_pitch_lag, enc_word_valid}), 32'({7'h28, 1'b0}));
        chk_word(32'(dec_frame_late), 32'h0);
        // A mark in mid-frame must pull the position back to zero
        for (int i = 0; i < 4; i++) send_dec(i % 3, 0);
        dec_word_valid = 1'b0;
      end
    end
    while (enc_q.size() > 0 || dec_q.size() > 0) step(n);
    chk_word(32'(refused > 0), 32'h1);
    report_and_stop();
  end
endmodule : speech_codec_frame_interface_bench
